// >>> sst_regs.svh
`ifndef SST_REGS_SVH
`define SST_REGS_SVH

`define SST_OFS_MODE 8'h00
`define SST_OFS_CTRL 8'h04
`define SST_OFS_BRR 8'h08
`define SST_OFS_TDR 8'h0c
`define SST_OFS_STAT 8'h10
`define SST_OFS_RDR 8'h14

`define SST_MODE_RST 8'h80
`define SST_CTRL_RST 8'h00
`define SST_BRR_RST 8'hff
`define SST_TDR_RST 8'hff
`define SST_RDR_RST 8'h00
`define SST_STAT_RST 8'h84

`define SST_BIT_LAST 3'h7
`define SST_RX_PAIR 5'h10
`define SST_RESP_OKAY 2'h0
`define SST_RESP_SLVERR 2'h2

`endif

// >>> sst_pkg.sv
`default_nettype none
package sst_pkg;

  typedef struct packed {
    logic sync_mode_select;
    logic char_len;
    logic parity_en;
    logic parity_odd;
    logic stop_len;
    logic mp_en;
    logic [1:0] clk_div;
  } sst_mode_t;

  typedef struct packed {
    logic tx_empty_irq_en;
    logic rx_irq_en;
    logic tx_enable;
    logic rx_enable;
    logic id_wait_enable;
    logic tx_done_irq_en;
    logic clk_source_sel_hi;
    logic clk_source_sel_lo;
  } sst_ctrl_t;

  typedef struct packed {
    logic tx_buffer_empty_flag;
    logic rx_full_flag;
    logic overrun_flag;
    logic framing_error_flag;
    logic parity_error_flag;
    logic tx_done_flag;
    logic [1:0] spare;
  } sst_stat_t;

  typedef struct packed {
    logic rise;
    logic fall;
  } sst_edge_t;

endpackage
`default_nettype wire

// >>> sst_brg.sv
`include "sst_regs.svh"
`default_nettype none
// Half-period tick every div+1 cycles while run is high
module sst_brg
  import sst_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic [7:0] div,
  output logic tick
);
  logic [7:0] cnt_r;
  wire at_end = (cnt_r == div);

  always_ff @(posedge aclk) begin
    if (!aresetn || !run || at_end) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

  assign tick = run && at_end;
endmodule // sst_brg
`default_nettype wire

// >>> sst_edge.sv
`include "sst_regs.svh"
`default_nettype none
// Edge pulses of the incoming serial clock level
module sst_edge
  import sst_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic lvl,
  output sst_edge_t edges
);
  logic prev_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_r <= 1'b1;
    end else begin
      prev_r <= lvl;
    end
  end

  assign edges.rise = lvl && !prev_r;
  assign edges.fall = !lvl && prev_r;
endmodule // sst_edge
`default_nettype wire

// >>> sst_sync_serial.sv
`include "sst_regs.svh"
`default_nettype none
module sst_sync_serial
  import sst_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_n,
  output logic txd_o,
  input wire logic rxd_i,
  output logic tx_empty_irq,
  output logic rx_full_irq,
  output logic rx_error_irq,
  output logic tx_done_irq
);

  function automatic logic sst_hit(input logic [7:0] a);
    return a == `SST_OFS_MODE || a == `SST_OFS_CTRL ||
           a == `SST_OFS_BRR || a == `SST_OFS_TDR ||
           a == `SST_OFS_STAT || a == `SST_OFS_RDR;
  endfunction

  // Bus side state
  logic aw_hold_r;
  logic w_hold_r;
  logic [7:0] aw_addr_r;
  logic [7:0] w_data_r;
  logic w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;

  // Registers
  sst_mode_t mode_r;
  sst_ctrl_t ctrl_r;
  logic [7:0] brr_r;
  logic [7:0] tdr_r;
  logic [7:0] rdr_r;
  sst_stat_t stat_r;
  sst_stat_t stat_nxt;

  // Serial engine state
  logic sck_r;
  logic txd_r;
  logic tx_run_r;
  logic [2:0] tx_bit_r;
  logic [7:0] tx_sh_r;
  logic [2:0] rx_bit_r;
  logic [7:0] rx_sh_r;
  logic [4:0] rx_left_r;

  logic brg_tick;
  sst_edge_t ext_e;

  // Write path
  wire wr_go = aw_hold_r && w_hold_r;
  wire wr_en = wr_go && w_strb_r;
  wire wr_mode = wr_en && aw_addr_r == `SST_OFS_MODE;
  wire wr_ctrl = wr_en && aw_addr_r == `SST_OFS_CTRL;
  wire wr_brr = wr_en && aw_addr_r == `SST_OFS_BRR;
  wire wr_tdr = wr_en && aw_addr_r == `SST_OFS_TDR;
  wire wr_stat = wr_en && aw_addr_r == `SST_OFS_STAT;
  wire sst_stat_t wst = sst_stat_t'(w_data_r);

  assign s_axi_awready = !aw_hold_r && !bvalid_r;
  assign s_axi_wready = !w_hold_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      aw_addr_r <= 8'h00;
    end else if (wr_go) begin
      aw_hold_r <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_r <= 1'b0;
      w_data_r <= 8'h00;
      w_strb_r <= 1'b0;
    end else if (wr_go) begin
      w_hold_r <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_r <= 1'b1;
      w_data_r <= s_axi_wdata[7:0];
      w_strb_r <= s_axi_wstrb[0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= `SST_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r <= sst_hit(aw_addr_r) ? `SST_RESP_OKAY : `SST_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Read path
  wire ar_go = s_axi_arvalid && !rvalid_r;
  wire [7:0] rd_mux =
    (s_axi_araddr == `SST_OFS_MODE) ? mode_r :
    (s_axi_araddr == `SST_OFS_CTRL) ? ctrl_r :
    (s_axi_araddr == `SST_OFS_BRR) ? brr_r :
    (s_axi_araddr == `SST_OFS_TDR) ? tdr_r :
    (s_axi_araddr == `SST_OFS_STAT) ? stat_r :
    (s_axi_araddr == `SST_OFS_RDR) ? rdr_r : 8'h00;

  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `SST_RESP_OKAY;
    end else if (ar_go) begin
      rvalid_r <= 1'b1;
      rdata_r <= {24'h00_0000, rd_mux};
      rresp_r <= sst_hit(s_axi_araddr) ? `SST_RESP_OKAY : `SST_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_r <= `SST_MODE_RST;
      ctrl_r <= `SST_CTRL_RST;
      brr_r <= `SST_BRR_RST;
      tdr_r <= `SST_TDR_RST;
    end else begin
      if (wr_mode) mode_r <= w_data_r;
      if (wr_ctrl) ctrl_r <= w_data_r;
      if (wr_brr) brr_r <= w_data_r;
      if (wr_tdr) tdr_r <= w_data_r;
    end
  end

  // Clock source and enables
  wire sync_on = mode_r.sync_mode_select;
  wire int_mode = sync_on && !ctrl_r.clk_source_sel_hi;
  wire ext_mode = sync_on && ctrl_r.clk_source_sel_hi;
  wire te = sync_on && ctrl_r.tx_enable;
  wire re = sync_on && ctrl_r.rx_enable;
  wire rx_err = stat_r.overrun_flag || stat_r.framing_error_flag ||
                stat_r.parity_error_flag;

  sst_brg u_brg (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(int_mode),
    .div(brr_r),
    .tick(brg_tick)
  );

  sst_edge u_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .lvl(sck_i),
    .edges(ext_e)
  );

  // Falls only with work pending; a low clock always returns high
  wire pending = tx_run_r || (rx_left_r != 5'h00);
  wire int_fall = int_mode && brg_tick && sck_r && pending;
  wire int_rise = int_mode && brg_tick && !sck_r;
  wire sck_fall = int_mode ? int_fall : (ext_mode && ext_e.fall);
  wire sck_rise = int_mode ? int_rise : (ext_mode && ext_e.rise);

  // Transmit sequencing
  wire tx_start = te && !tx_run_r && !stat_r.tx_buffer_empty_flag &&
                  !rx_err;
  wire tx_last = sck_fall && tx_run_r && tx_bit_r == `SST_BIT_LAST;
  wire tx_chain = tx_last && te && !stat_r.tx_buffer_empty_flag &&
                  !rx_err;
  wire tx_load = tx_start || tx_chain;
  wire tx_end = tx_last && !tx_chain;

  // Receive sequencing
  wire rx_act = re && !rx_err;
  wire rx_shift = sck_rise && rx_act;
  wire rx_done = rx_shift && rx_bit_r == `SST_BIT_LAST;
  wire rx_store = rx_done && !stat_r.rx_full_flag;
  wire rx_ovr = rx_done && stat_r.rx_full_flag;
  wire rx_pair_go = int_mode && rx_act && !te && sck_r && !pending &&
                    !stat_r.rx_full_flag;

  always_ff @(posedge aclk) begin
    if (!aresetn || !int_mode) begin
      sck_r <= 1'b1;
    end else if (int_fall) begin
      sck_r <= 1'b0;
    end else if (int_rise) begin
      sck_r <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_run_r <= 1'b0;
      tx_bit_r <= 3'h0;
      tx_sh_r <= `SST_TDR_RST;
    end else if (!te) begin
      tx_run_r <= 1'b0;
      tx_bit_r <= 3'h0;
      tx_sh_r <= `SST_TDR_RST;
    end else if (tx_load) begin
      tx_sh_r <= tdr_r;
      tx_run_r <= 1'b1;
      tx_bit_r <= 3'h0;
    end else if (tx_end) begin
      tx_run_r <= 1'b0;
    end else if (sck_fall && tx_run_r) begin
      tx_bit_r <= tx_bit_r + 3'h1;
    end
  end

  // Line holds the last bit sent when idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txd_r <= 1'b1;
    end else if (sck_fall && tx_run_r) begin
      txd_r <= tx_sh_r[tx_bit_r];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_bit_r <= 3'h0;
      rx_sh_r <= 8'h00;
    end else if (!rx_act) begin
      rx_bit_r <= 3'h0;
    end else if (rx_shift) begin
      rx_sh_r <= {rxd_i, rx_sh_r[7:1]};
      rx_bit_r <= rx_bit_r + 3'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdr_r <= `SST_RDR_RST;
    end else if (rx_store) begin
      rdr_r <= {rxd_i, rx_sh_r[7:1]};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !rx_act || !int_mode) begin
      rx_left_r <= 5'h00;
    end else if (rx_pair_go) begin
      rx_left_r <= `SST_RX_PAIR;
    end else if (sck_rise && rx_left_r != 5'h00) begin
      rx_left_r <= rx_left_r - 5'h01;
    end
  end

  // Status: software writes 0 to clear; hardware sets win
  always_comb begin
    stat_nxt = stat_r;
    if (wr_stat) begin
      stat_nxt.tx_buffer_empty_flag = stat_r.tx_buffer_empty_flag &
                                      wst.tx_buffer_empty_flag;
      stat_nxt.rx_full_flag = stat_r.rx_full_flag & wst.rx_full_flag;
      stat_nxt.overrun_flag = stat_r.overrun_flag & wst.overrun_flag;
      stat_nxt.framing_error_flag = stat_r.framing_error_flag &
                                    wst.framing_error_flag;
      stat_nxt.parity_error_flag = stat_r.parity_error_flag &
                                   wst.parity_error_flag;
      stat_nxt.tx_done_flag = stat_r.tx_done_flag & wst.tx_done_flag;
    end
    if (tx_load) begin
      stat_nxt.tx_done_flag = 1'b0;
    end
    if (!te || tx_load) begin
      stat_nxt.tx_buffer_empty_flag = 1'b1;
    end
    if (tx_end) begin
      stat_nxt.tx_done_flag = 1'b1;
    end
    if (rx_store) begin
      stat_nxt.rx_full_flag = 1'b1;
    end
    if (rx_ovr) begin
      stat_nxt.overrun_flag = 1'b1;
    end
    stat_nxt.spare = 2'h0;
  end

  // Receive disable leaves flags and data alone
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_r <= `SST_STAT_RST;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  assign sck_o = sck_r;
  assign sck_oe_n = !int_mode;
  assign txd_o = txd_r;
  assign tx_empty_irq = stat_r.tx_buffer_empty_flag &&
                        ctrl_r.tx_empty_irq_en;
  assign rx_full_irq = stat_r.rx_full_flag && ctrl_r.rx_irq_en;
  assign rx_error_irq = stat_r.overrun_flag && ctrl_r.rx_irq_en;
  assign tx_done_irq = stat_r.tx_done_flag && ctrl_r.tx_done_irq_en;

endmodule // sst_sync_serial
`default_nettype wire

// >>> sst_sync_serial_monitor.sv
`default_nettype none
module sst_sync_serial_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sck_o,
  input wire logic sck_oe_n,
  input wire logic txd_o,
  input wire logic rx_full_irq,
  input wire logic rx_error_irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_sck_high: assert property (
    $fell(sck_o) |-> ##[1:256] sck_o) else $error("clock stuck low");
  a_txd_rise: assert property (
    !sck_oe_n && !$past(sck_o) && $changed(txd_o) |-> !sck_o)
    else $error("data moved at rising clock");
  a_ext_quiet: assert property (
    sck_oe_n && $past(sck_oe_n) |-> $stable(sck_o))
    else $error("clock driven in external mode");
  a_err_full: assert property (
    $rose(rx_error_irq) |-> rx_full_irq) else $error("overrun not full");
  a_b_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid |-> ##[1:3] s_axi_bvalid)
    else $error("no write response");
  a_b_done: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_r_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read response");
  a_r_done: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");

  c_wr: cover property (s_axi_bvalid && s_axi_bready);
  c_fall: cover property ($fell(sck_o));
  c_err: cover property ($rose(rx_error_irq));
endmodule // sst_sync_serial_monitor

bind sst_sync_serial sst_sync_serial_monitor u_mon (
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .sck_o(sck_o), .sck_oe_n(sck_oe_n),
  .txd_o(txd_o), .rx_full_irq(rx_full_irq), .rx_error_irq(rx_error_irq)
);
`default_nettype wire

// >>> sst_peer.sv
`default_nettype none
module sst_peer (
  input wire logic sck,
  input wire logic txd,
  input wire logic [7:0] pat,
  output logic rxd,
  output logic [15:0] got
);
  timeunit 1ns;
  timeprecision 1ns;
  int n = 0;
  initial rxd = 1'b1;
  initial got = 16'h0000;
  // Sample where the device holds data stable
  always @(posedge sck) got <= {txd, got[15:1]};
  // Next bit from each falling edge, lowest first
  always @(negedge sck) begin
    rxd <= pat[n];
    n <= (n + 1) % 8;
  end
endmodule // sst_peer
`default_nettype wire

// >>> sst_sync_serial_test.sv
`default_nettype none
module sst_sync_serial_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 0, aresetn = 0, ext_sck = 1'b1;
  logic [7:0] pat = 8'h96;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, sck_o, sck_oe_n, txd_o, rxd;
  logic tx_empty_irq, rx_full_irq, rx_error_irq, tx_done_irq;
  logic [15:0] got;
  int fails = 0, comparisons = 0, cyc = 0, falls = 0;
  wire logic sck = sck_oe_n ? ext_sck : sck_o;

  sst_sync_serial dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sck_i(sck), .sck_o,
    .sck_oe_n, .txd_o, .rxd_i(rxd), .tx_empty_irq, .rx_full_irq,
    .rx_error_irq, .tx_done_irq);
  sst_peer peer (.sck(sck), .txd(txd_o), .pat(pat), .rxd(rxd),
    .got(got));

  always #50 aclk = ~aclk;
  always @(negedge sck_o) falls++;
  always @(posedge aclk) begin
    cyc++;
    if (cyc > 30000) begin
      fails++;
      finish_test();
    end
  end

  task automatic finish_test;
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, 32'h0);
    // One edge between transfers
    @(posedge aclk);
  endtask

  task automatic get(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input logic [1:0] er);
    get(a);
    chk(d, {24'h000000, e});
    chk(r, er);
  endtask

  // Read status until every bit of the mask is set
  task automatic poll(input logic [7:0] m);
    do get(8'h10);
    while ((d[7:0] & m) != m);
  endtask

  task automatic t_reset;
    rd(8'h10, 8'h84, 2'h0);
    rd(8'h04, 8'h00, 2'h0);
    rd(8'h20, 8'h00, 2'h2);
    // Write without the low byte lane is ignored
    s_axi_wstrb <= 4'h0;
    wr(8'h08, 8'h55);
    s_axi_wstrb <= 4'hf;
    rd(8'h08, 8'hff, 2'h0);
    chk({sck_oe_n, sck_o}, 32'h1);
    wr(8'h04, 8'h02);
    chk(sck_oe_n, 32'h1);
    wr(8'h04, 8'h00);
  endtask

  // Two chained characters out, two in with the second overrunning
  task automatic t_txrx;
    wr(8'h08, 8'h01);
    repeat (4) @(posedge aclk);
    wr(8'h04, 8'hf4);
    chk(tx_empty_irq, 32'h1);
    wr(8'h0c, 8'ha5);
    wr(8'h10, 8'h7f);
    poll(8'h80);
    wr(8'h0c, 8'h3c);
    wr(8'h10, 8'h7f);
    poll(8'h24);
    chk(got, 32'h3ca5);
    chk(txd_o, 32'h0);
    chk(sck_o, 32'h1);
    chk(tx_done_irq, 32'h1);
    chk(rx_error_irq, 32'h1);
    chk(rx_full_irq, 32'h1);
    rd(8'h14, 8'h96, 2'h0);
    rd(8'h10, 8'he4, 2'h0);
  endtask

  task automatic t_block;
    int f;
    f = falls;
    wr(8'h0c, 8'h11);
    wr(8'h10, 8'h7f);
    repeat (20) @(posedge aclk);
    rd(8'h10, 8'h64, 2'h0);
    chk(falls - f, 32'h0);
    wr(8'h04, 8'hc4);
    rd(8'h10, 8'he4, 2'h0);
    rd(8'h14, 8'h96, 2'h0);
    wr(8'h10, 8'h9f);
    rd(8'h10, 8'h84, 2'h0);
    chk(rx_error_irq, 32'h0);
  endtask

  task automatic t_rxonly;
    int f;
    f = falls;
    wr(8'h04, 8'h10);
    poll(8'h60);
    repeat (100) @(posedge aclk);
    chk(falls - f, 32'd16);
    rd(8'h14, 8'h96, 2'h0);
  endtask

  // External clock: one character each way
  task automatic t_ext;
    int f;
    f = falls;
    wr(8'h04, 8'h00);
    wr(8'h10, 8'h9f);
    wr(8'h04, 8'h02);
    repeat (8) @(posedge aclk);
    wr(8'h04, 8'h32);
    wr(8'h0c, 8'ha6);
    wr(8'h10, 8'h7f);
    pat <= 8'h69;
    repeat (8) begin
      repeat (4) @(posedge aclk);
      ext_sck <= 1'b0;
      repeat (4) @(posedge aclk);
      ext_sck <= 1'b1;
    end
    repeat (4) @(posedge aclk);
    chk(got[15:8], 32'ha6);
    chk(txd_o, 32'h1);
    chk(falls - f, 32'h0);
    chk(sck_oe_n, 32'h1);
    rd(8'h10, 8'hc4, 2'h0);
    rd(8'h14, 8'h69, 2'h0);
  endtask

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_txrx();
    t_block();
    t_rxonly();
    t_ext();
    finish_test();
  end
endmodule // sst_sync_serial_test
`default_nettype wire
